// file: logic/usbem_top.sv
// Bulk-out interrupt clear register and endpoint-1 interface mapping logic
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module usbem_top (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire usbem_pkg::usbem_ahb_req_t i_ahb,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire usbem_pkg::usbem_evt_t i_hw_set,
  input wire usbem_pkg::usbem_evt_t i_hw_clr,
  input wire logic i_device_set_up_flag,
  input wire usbem_pkg::usbem_alt_t i_alt_setting,
  input wire logic i_ep2_valid,
  output logic o_ep1_valid,
  output usbem_pkg::usbem_evt_t o_bulk_out_irq_status,
  output logic o_irq
);
  import usbem_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] idx_of(input logic [31:0] addr);
    idx_of = {2'h0, addr[31:2]};
  endfunction

  function automatic logic is_mapped(input logic [31:0] idx);
    is_mapped = (idx == USBEM_IDX_IRQ_CLEAR) ||
                (idx == USBEM_IDX_EP1_MAP) ||
                (idx == USBEM_IDX_IRQ_STATUS) ||
                (idx == USBEM_IDX_IRQ_MASK) ||
                (idx == USBEM_IDX_EP_STATE);
  endfunction

  function automatic logic [7:0] alt_of(input usbem_alt_t alt,
                                        input logic [2:0] iface);
    logic [7:0] sel;
    sel = 8'h00;
    unique case (iface)
      3'h0: sel = alt.if0;
      3'h1: sel = alt.if1;
      3'h2: sel = alt.if2;
      3'h3: sel = alt.if3;
      3'h4: sel = alt.if4;
      default: sel = 8'h00;
    endcase
    alt_of = sel;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  usbem_state_t st_r;
  usbem_state_t st_nxt;

  logic [2:0] link;
  logic linked;
  logic [2:0] iface;
  logic [7:0] cur_alt;
  logic [3:0] five_alt;
  logic two_alt1;
  logic alt_ok;
  logic ep1_valid;
  logic take;
  logic [7:0] wr_byte;
  logic [7:0] sw_clr;
  logic [7:0] hw_set;
  logic [7:0] hw_clr;

  // ------------------------------------------------------------------
  // Endpoint-1 validity
  // ------------------------------------------------------------------
  always_comb begin
    link = st_r.ep1_map[USBEM_LINK_MSB:USBEM_LINK_LSB];
    // Codes 110 and 111 fall outside 1..5 and never link
    linked = (link != USBEM_LINK_NONE) && (link <= USBEM_LINK_IF4);
    iface = link - 3'h1;
    cur_alt = alt_of(i_alt_setting, iface);
    five_alt = st_r.ep1_map[USBEM_FIVE_MSB:0];
    two_alt1 = st_r.ep1_map[USBEM_TWO_ALT1_BIT];
    alt_ok = 1'b0;
    if (cur_alt == 8'h00) begin
      // Alternate 0 is always part of the link
      alt_ok = 1'b1;
    end else if (five_alt != 4'h0) begin
      if (cur_alt <= 8'h04) begin
        alt_ok = five_alt[cur_alt[1:0] - 2'h1];
      end
    end else begin
      // Two-series bit only counts when no five-series bit is set
      alt_ok = two_alt1 && (cur_alt == 8'h01);
    end
    ep1_valid = linked && i_device_set_up_flag && alt_ok;
  end

  // ------------------------------------------------------------------
  // Bus decode and register updates
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    take = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
    wr_byte = i_ahb.hwdata[7:0];
    sw_clr = 8'h00;
    hw_set = i_hw_set;
    hw_clr = i_hw_clr;

    unique case (st_r.bus)
      USBEM_BUS_IDLE: begin
      end
      USBEM_BUS_WRITE: begin
        if (st_r.idx == USBEM_IDX_IRQ_CLEAR) begin
          // Zeros clear; ones and the register itself hold nothing
          sw_clr = ~wr_byte;
        end
        if (st_r.idx == USBEM_IDX_EP1_MAP) begin
          st_nxt.ep1_map = wr_byte;
        end
        if (st_r.idx == USBEM_IDX_IRQ_STATUS) begin
          sw_clr = wr_byte;
        end
        if (st_r.idx == USBEM_IDX_IRQ_MASK) begin
          st_nxt.mask = wr_byte;
        end
      end
      USBEM_BUS_RDWAIT: begin
        // Read one cycle late so a write just before is seen
        st_nxt.hrdata = 32'h00000000;
        if (st_r.idx == USBEM_IDX_IRQ_CLEAR) begin
          st_nxt.hrdata = {24'h000000, USBEM_RST_IRQ_CLEAR};
        end
        if (st_r.idx == USBEM_IDX_EP1_MAP) begin
          st_nxt.hrdata = {24'h000000, st_r.ep1_map};
        end
        if (st_r.idx == USBEM_IDX_IRQ_STATUS) begin
          st_nxt.hrdata = {24'h000000, st_r.status};
        end
        if (st_r.idx == USBEM_IDX_IRQ_MASK) begin
          st_nxt.hrdata = {24'h000000, st_r.mask};
        end
        if (st_r.idx == USBEM_IDX_EP_STATE) begin
          st_nxt.hrdata = {29'h0000000, i_ep2_valid,
                           i_device_set_up_flag, ep1_valid};
        end
      end
      USBEM_BUS_RDDONE: begin
      end
    endcase

    // Endpoints not valid ignore their clear bits
    sw_clr[USBEM_EP2_LSB-1:0] = sw_clr[USBEM_EP2_LSB-1:0] &
                                {4{ep1_valid}};
    sw_clr[7:USBEM_EP2_LSB] = sw_clr[7:USBEM_EP2_LSB] &
                              {4{i_ep2_valid}};

    // Either clear drops the flag; a new event in that cycle wins
    st_nxt.status = (st_r.status & ~(hw_clr | sw_clr)) | hw_set;

    // Next bus phase; reads stall one cycle, writes answer at once
    if (st_r.bus == USBEM_BUS_RDWAIT) begin
      st_nxt.bus = USBEM_BUS_RDDONE;
    end else if (take && is_mapped(idx_of(i_ahb.haddr))) begin
      st_nxt.idx = idx_of(i_ahb.haddr);
      st_nxt.bus = i_ahb.hwrite ? USBEM_BUS_WRITE : USBEM_BUS_RDWAIT;
    end else if (take && !i_ahb.hwrite) begin
      // Unmapped reads still answer, with zero data
      st_nxt.idx = 32'h00000000;
      st_nxt.bus = USBEM_BUS_RDWAIT;
    end else begin
      st_nxt.idx = 32'h00000000;
      st_nxt.bus = USBEM_BUS_IDLE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_r.bus <= USBEM_BUS_IDLE;
      st_r.idx <= 32'h00000000;
      st_r.hrdata <= 32'h00000000;
      st_r.status <= USBEM_RST_IRQ_STATUS;
      st_r.mask <= USBEM_RST_IRQ_MASK;
      st_r.ep1_map <= USBEM_RST_EP1_MAP;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign o_hrdata = st_r.hrdata;
  assign o_hreadyout = (st_r.bus != USBEM_BUS_RDWAIT);
  assign o_hresp = 1'b0;
  assign o_ep1_valid = ep1_valid;
  assign o_bulk_out_irq_status = st_r.status;
  assign o_irq = |(st_r.status & st_r.mask);

endmodule
`default_nettype wire

// file: pkg/usbem_pkg.sv
// Constants, types and register map of the USB endpoint map / irq clear block
// Functional notes
// - Clear register is write-only, byte wide; every read returns all ones.
// - Writing 0 to a clear bit clears the matching bulk-out status flag.
// - Clear bits return to 1 by themselves; writing 1 does nothing.
// - Software may clear a flag before hardware clears it automatically.
// - Clear bits do nothing while their endpoint is not currently valid.
// - Bits 7/3 clear buffer-full, bits 6/2 clear null-packet for EP2/EP1.
// - Bits 5/1 clear NAK, bits 4/0 clear data-received for EP2/EP1.
// - Endpoint-1 validity steers status, feature and IN answers to EP1.
// - Link field bits 7-5: 0 none, 1-5 interfaces 0-4 alt 0, 6-7 none.
// - Link codes 110 and 111 keep EP1 invalid whatever the alt bits say.
// - A linked EP1 becomes valid once the configured flag is 1.
// - EP1 linked at alternate 0 is valid in alternates 1 to 4 only where bits 4-0 allow it.
// - Bit 4 set validates EP1 in alternate 1 when configured; default off.
// - Bit 4 only counts while bits 3-0 are all zero.
// - Bit n-1 set validates EP1 in alternate n, n 1 to 4, when configured.
package usbem_pkg;

  // ------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [31:0] USBEM_IDX_IRQ_CLEAR = 32'h00200042;
  localparam logic [31:0] USBEM_IDX_EP1_MAP = 32'h00200086;
  localparam logic [31:0] USBEM_IDX_IRQ_STATUS = 32'h00200044;
  localparam logic [31:0] USBEM_IDX_IRQ_MASK = 32'h00200045;
  localparam logic [31:0] USBEM_IDX_EP_STATE = 32'h00200046;

  // ------------------------------------------------------------------
  // Reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] USBEM_RST_IRQ_CLEAR = 8'hff;
  localparam logic [7:0] USBEM_RST_EP1_MAP = 8'h00;
  localparam logic [7:0] USBEM_RST_IRQ_STATUS = 8'h00;
  localparam logic [7:0] USBEM_RST_IRQ_MASK = 8'h00;
  localparam int USBEM_LINK_MSB = 7;
  localparam int USBEM_LINK_LSB = 5;
  localparam int USBEM_TWO_ALT1_BIT = 4;
  localparam int USBEM_FIVE_MSB = 3;
  localparam int USBEM_EP2_LSB = 4;
  localparam logic [2:0] USBEM_LINK_NONE = 3'h0;
  localparam logic [2:0] USBEM_LINK_IF4 = 3'h5;
  localparam int USBEM_NUM_IFACE = 5;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic full;
    logic null_pkt;
    logic nak;
    logic data;
  } usbem_ep_evt_t;

  // Index 1 is EP2 (bits 7:4), index 0 is EP1 (bits 3:0)
  typedef usbem_ep_evt_t [1:0] usbem_evt_t;

  typedef struct packed {
    logic [7:0] if4;
    logic [7:0] if3;
    logic [7:0] if2;
    logic [7:0] if1;
    logic [7:0] if0;
  } usbem_alt_t;

  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } usbem_ahb_req_t;

  typedef enum logic [3:0] {
    USBEM_BUS_IDLE = 4'b0001,
    USBEM_BUS_WRITE = 4'b0010,
    USBEM_BUS_RDWAIT = 4'b0100,
    USBEM_BUS_RDDONE = 4'b1000
  } usbem_bus_t;

  typedef struct packed {
    usbem_bus_t bus;
    logic [31:0] idx;
    logic [31:0] hrdata;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] ep1_map;
  } usbem_state_t;

endpackage

// file: tb/usb_endpoint_map_irq_clear_tb_top.sv
// Self-checking bench for the endpoint map and bulk-out clear block
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_map_irq_clear_tb_top;
  import usbem_pkg::*;
  localparam logic [31:0] A_CLR = USBEM_IDX_IRQ_CLEAR << 2;
  localparam logic [31:0] A_MAP = USBEM_IDX_EP1_MAP << 2;
  localparam logic [31:0] A_STS = USBEM_IDX_IRQ_STATUS << 2;
  localparam logic [31:0] A_MSK = USBEM_IDX_IRQ_MASK << 2;
  localparam logic [31:0] A_EPS = USBEM_IDX_EP_STATE << 2;
  logic i_clk = 0, i_srst = 1, cfg = 0, set_if = 0, ep2 = 0, rd_dp = 0;
  logic [2:0] ifc = 0;
  logic [7:0] alt = 0;
  usbem_ahb_req_t m = '0, bus;
  usbem_evt_t hw_set = '0, hw_clr = '0, sts;
  usbem_alt_t alts;
  logic device_set_up_flag, ep1v, rdy, resp, irq;
  logic [31:0] rdata;
  logic [31:0] exp_q[$];
  int err_total = 0, checks = 0;
  always_comb begin
    bus = m;
    bus.hready = rdy;
  end
  usbem_host_model i_usbem_host_model (.i_clk(i_clk), .i_srst(i_srst),
    .i_cfg(cfg), .i_set_if(set_if), .i_iface(ifc), .i_alt(alt),
    .o_device_set_up_flag(device_set_up_flag), .o_alt(alts));
  usbem_top i_usbem_top (.i_clk(i_clk), .i_srst(i_srst), .i_ahb(bus),
    .o_hrdata(rdata), .o_hreadyout(rdy), .o_hresp(resp), .i_hw_set(hw_set),
    .i_hw_clr(hw_clr), .i_device_set_up_flag(device_set_up_flag), .i_alt_setting(alts),
    .i_ep2_valid(ep2), .o_ep1_valid(ep1v), .o_bulk_out_irq_status(sts),
    .o_irq(irq));
  initial forever #20 i_clk = ~i_clk;
  task automatic stop_test;
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Read data is judged where the master takes it
  always @(posedge i_clk) begin
    if (rd_dp && rdy === 1'b1) chk("hrdata", rdata, exp_q.pop_front());
    if (rd_dp && rdy === 1'b1) chk("hresp", resp, 32'h0);
    if (rdy === 1'b1) rd_dp <= m.hsel && m.htrans[1] && !m.hwrite;
  end
  // Negedge look equals what the next rising edge samples
  task automatic wait_rdy;
    do @(negedge i_clk); while (rdy !== 1'b1);
    @(posedge i_clk);
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    m.hsel <= 1'b1;
    m.htrans <= 2'h2;
    m.haddr <= a;
    m.hwrite <= w;
    m.hsize <= 3'h2;
    wait_rdy;
    m.hsel <= 1'b0;
    m.htrans <= 2'h0;
    m.hwdata <= d;
    wait_rdy;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic pulse(input logic [7:0] s, input logic [7:0] c);
    hw_set <= s;
    hw_clr <= c;
    @(posedge i_clk);
    hw_set <= '0;
    hw_clr <= '0;
    @(posedge i_clk);
  endtask
  task automatic host(input logic c, input logic [2:0] f, input logic [7:0] a);
    cfg <= c;
    ifc <= f;
    alt <= a;
    set_if <= 1'b1;
    @(posedge i_clk);
    set_if <= 1'b0;
    @(posedge i_clk);
  endtask
  function automatic logic ev(logic [7:0] mp, logic [7:0] a, logic cf);
    if (!cf || mp[7:5] == 3'h0 || mp[7:5] > 3'h5) return 1'b0;
    if (a == 8'h0) return 1'b1;
    if (mp[3:0] != 4'h0) return (a < 8'h5) && mp[a - 8'h1];
    return (a == 8'h1) && mp[4];
  endfunction
  initial begin
    logic [7:0] v;
    static logic [7:0] maps[6] = '{8'h20, 8'h50, 8'h45, 8'hd0, 8'hf8,
                                   8'h0f};
    void'($urandom(73));
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(A_CLR, 32'hff);
    rd(A_MAP, 32'h0);
    rd(A_STS, 32'h0);
    rd(A_MSK, 32'h0);
    rd(A_STS + 32'h40, 32'h0);
    wr(A_CLR, 8'h00);
    rd(A_CLR, 32'hff);
    repeat (4) begin
      v = 8'($urandom);
      wr(A_MAP, v);
      rd(A_MAP, {24'h0, v});
    end
    for (int c = 0; c < 2; c++) begin
      foreach (maps[i]) begin
        for (int a = 0; a < 6; a++) begin
          ep2 <= 1'($urandom);
          wr(A_MAP, maps[i]);
          host(c[0], maps[i][7:5] - 3'h1, a[7:0]);
          @(negedge i_clk);
          chk("ep1_valid", ep1v, {31'h0, ev(maps[i], a[7:0], c[0])});
          @(posedge i_clk);
          rd(A_EPS, {29'h0, ep2, c[0], ev(maps[i], a[7:0], c[0])});
        end
      end
    end
    ep2 <= 1'b1;
    wr(A_MAP, 8'h20);
    host(1'b1, 3'h0, 8'h0);
    wr(A_MSK, 8'h01);
    pulse(8'hff, 8'h00);
    rd(A_STS, 32'hff);
    @(negedge i_clk);
    chk("irq", irq, 32'h1);
    // Realign so the next request starts right after a rising edge
    @(posedge i_clk);
    for (int b = 0; b < 8; b++) begin
      wr(A_CLR, ~(8'h01 << b));
      rd(A_STS, {24'h0, 8'hff << (b + 1)});
    end
    @(negedge i_clk);
    chk("irq", irq, 32'h0);
    @(posedge i_clk);
    pulse(8'hff, 8'h00);
    wr(A_CLR, 8'hff);
    rd(A_STS, 32'hff);
    pulse(8'h00, 8'h0f);
    rd(A_STS, 32'hf0);
    wr(A_CLR, 8'h0f);
    pulse(8'h00, 8'hf0);
    rd(A_STS, 32'h0);
    pulse(8'h0f, 8'h00);
    wr(A_CLR, 8'hf0);
    rd(A_STS, 32'h0);
    wr(A_MAP, 8'h00);
    pulse(8'hff, 8'h00);
    wr(A_CLR, 8'h00);
    rd(A_STS, 32'h0f);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(A_STS, 32'h0);
    stop_test;
  end
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
endmodule
`default_nettype wire

// file: tb/usbem_host_model.sv
// Host-side model: configuration and per-interface alternate settings
`timescale 1ns/10ps
`default_nettype none
module usbem_host_model (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cfg,
  input wire logic i_set_if,
  input wire logic [2:0] i_iface,
  input wire logic [7:0] i_alt,
  output logic o_device_set_up_flag,
  output usbem_pkg::usbem_alt_t o_alt
);
  import usbem_pkg::*;
  logic [39:0] alt_r = '0;
  assign o_alt = alt_r;
  // Deconfiguring drops every interface back to alternate 0
  always_ff @(posedge i_clk) begin
    o_device_set_up_flag <= !i_srst && i_cfg;
    if (i_srst || !i_cfg) begin
      alt_r <= '0;
    end else if (i_set_if && i_iface < 3'h5) begin
      alt_r[i_iface * 8 +: 8] <= i_alt;
    end
  end
endmodule
`default_nettype wire

// file: tb/usbem_monitor.sv
// Port-level checks of the bulk-out clear and endpoint-1 map block
`timescale 1ns/10ps
`default_nettype none
module usbem_monitor (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire usbem_pkg::usbem_ahb_req_t i_ahb,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire usbem_pkg::usbem_evt_t i_hw_set,
  input wire usbem_pkg::usbem_evt_t i_hw_clr,
  input wire logic i_device_set_up_flag,
  input wire usbem_pkg::usbem_alt_t i_alt_setting,
  input wire logic i_ep2_valid,
  input wire logic o_ep1_valid,
  input wire usbem_pkg::usbem_evt_t o_bulk_out_irq_status,
  input wire logic o_irq
);
  import usbem_pkg::*;
  localparam logic [31:0] CLR_A = USBEM_IDX_IRQ_CLEAR << 2;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_take(logic [31:0] a, logic w);
    i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1] && i_ahb.hwrite == w
      && i_ahb.haddr == a;
  endsequence
  sequence s_wdp;
    s_take(CLR_A, 1'b1) ##1 o_hreadyout;
  endsequence
  property p_rd_clr;
    s_take(CLR_A, 1'b0) |=> !o_hreadyout ##1 (o_hreadyout && o_hrdata == 32'hff);
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("clear read not ff");
  property p_clr0;
    s_wdp ##0 (i_ahb.hwdata[3:0] == 4'h0 && o_ep1_valid && i_hw_set[0] == '0)
      |=> o_bulk_out_irq_status[0] == '0;
  endproperty
  a_clr0: assert property (p_clr0) else $error("ep1 flags kept");
  property p_inv;
    s_wdp ##0 (!o_ep1_valid && i_hw_set[0] == '0 && i_hw_clr[0] == '0)
      |=> $stable(o_bulk_out_irq_status[0]);
  endproperty
  a_inv: assert property (p_inv) else $error("invalid ep cleared");
  property p_one;
    s_wdp ##0 (i_ahb.hwdata[7:0] == 8'hff && i_hw_clr == '0)
      |=> o_bulk_out_irq_status == ($past(o_bulk_out_irq_status) | $past(i_hw_set));
  endproperty
  a_one: assert property (p_one) else $error("write of ones acted");
  property p_hwclr;
    i_hw_clr != '0 && i_hw_set == '0
      |=> (o_bulk_out_irq_status & $past(i_hw_clr)) == '0;
  endproperty
  a_hwclr: assert property (p_hwclr) else $error("hw clear lost");
  property p_set;
    i_hw_set != '0 |=> (o_bulk_out_irq_status & $past(i_hw_set)) == $past(i_hw_set);
  endproperty
  a_set: assert property (p_set) else $error("event not latched");
  property p_irq;
    o_irq |-> o_bulk_out_irq_status != '0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");
  property p_device_set_up_flag;
    o_ep1_valid |-> i_device_set_up_flag;
  endproperty
  a_device_set_up_flag: assert property (p_device_set_up_flag) else $error("ep1 valid unconfigured");
endmodule
bind usbem_top usbem_monitor i_usbem_monitor (.*);
`default_nettype wire
